// *** include/timer_pkg.sv ***
// Constants and types shared by the prescaled timer match core
// Overview of operation
// R1 - The timer advances by one when the divider count hits its limit.
// R2 - Unless cleared first, the timer counts through all ones to zero.
// R3 - A rollover of the timer counter raises no interrupt and sets no flag.
// R4 - Software that must see a rollover programs a compare channel for it.
// R5 - A 32-bit divider limit register sets the top of the divider count.
// R6 - While enabled the 32-bit divider count increments on every clock below the limit.
// R7 - At the limit the next clock bumps the timer and zeroes the divider.
// R8 - The timer advances once every limit plus one clocks.
// R9 - With irq bit 0, 3, 6 or 9 set, a match raises an interrupt.
// R10 - With clear bit 1, 4, 7 or 10 set, a match resets the timer.
// R11 - With halt bit 2, 5, 8 or 11 set, a match stops both counters.
// R12 - Match control resets to zero; software writes no ones above bit 11.
// R13 - Both counters advance only while the run enable bit is one.
// R14 - While the run clear bit is one both counters are held at zero.
// R15 - A channel interrupt sets its flag; writing one clears, zero keeps it.
// R16 - Every compare value is compared with the timer on every clock.
// R17 - The interrupt output is high while any pending flag is set.
`default_nettype none
package timer_pkg;
  localparam int          NUM_CH       = 4;
  localparam int          MCA_WIDTH    = 12;
  localparam int          BITS_PER_CH  = 3;
  localparam int          IRQ_BIT      = 0;
  localparam int          CLEAR_BIT    = 1;
  localparam int          HALT_BIT     = 2;
  localparam int          EN_BIT       = 0;
  localparam int          RST_BIT      = 1;
  localparam logic [31:0] ADDR_PENDING = 32'h4001_4000;
  localparam logic [31:0] ADDR_RUN     = 32'h4001_4004;
  localparam logic [31:0] ADDR_TICK    = 32'h4001_4008;
  localparam logic [31:0] ADDR_LIMIT   = 32'h4001_400c;
  localparam logic [31:0] ADDR_DIVCNT  = 32'h4001_4010;
  localparam logic [31:0] ADDR_MCA     = 32'h4001_4014;
  localparam logic [31:0] ADDR_CV0     = 32'h4001_4018;
  localparam logic [31:0] ADDR_CV1     = 32'h4001_401c;
  localparam logic [31:0] ADDR_CV2     = 32'h4001_4020;
  localparam logic [31:0] ADDR_CV3     = 32'h4001_4024;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [11:0] RESET_MCA    = 12'h000;

  typedef struct packed {
    logic [31:0]             tick_count;
    logic [31:0]             divider_count;
    logic [31:0]             divider_limit;
    logic [MCA_WIDTH-1:0]    match_action_control;
    logic [NUM_CH-1:0][31:0] compare_value;
    logic                    run_enable;
    logic                    run_clear;
    logic [NUM_CH-1:0]       pending_flags;
    logic [31:0]             rdata;
    logic                    ready;
    logic                    slverr;
    logic                    irq;
  } core_state_t;

  typedef struct packed {
    logic [NUM_CH-1:0] prev_hit;
  } unit_state_t;
endpackage
`default_nettype wire

// *** include/match_if.sv ***
// Signals between the timer core and its compare unit
`default_nettype none
interface match_if;
  import timer_pkg::*;
  logic [31:0]             tick_count;
  logic [NUM_CH-1:0][31:0] compare_value;
  logic [MCA_WIDTH-1:0]    match_action_control;
  logic [NUM_CH-1:0]       hit;
  logic [NUM_CH-1:0]       irq_event;
  logic [NUM_CH-1:0]       clear_hit;
  logic [NUM_CH-1:0]       halt_event;
  modport core (output tick_count, compare_value, match_action_control,
                input  hit, irq_event, clear_hit, halt_event);
  modport unit (input  tick_count, compare_value, match_action_control,
                output hit, irq_event, clear_hit, halt_event);
endinterface
`default_nettype wire

// *** verilog/match_unit.sv ***
// Per-channel comparators and match action decode
`default_nettype none
module match_unit (
  input  wire logic pclk,
  input  wire logic presetn,
  match_if.unit     mi
);
  import timer_pkg::*;

  unit_state_t s;
  unit_state_t next_s;

  ////////////////////////////////////////////////////////////////////////
  // Events fire on the first cycle of equality, so a long prescale period
  // does not raise the same interrupt or halt again and again.
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      assign mi.hit[i]        = mi.tick_count == mi.compare_value[i]; // R16
      assign mi.irq_event[i]  = mi.hit[i] & ~s.prev_hit[i] &
        mi.match_action_control[i*BITS_PER_CH+IRQ_BIT]; // R9
      assign mi.clear_hit[i]  = mi.hit[i] &
        mi.match_action_control[i*BITS_PER_CH+CLEAR_BIT]; // R10
      assign mi.halt_event[i] = mi.hit[i] & ~s.prev_hit[i] &
        mi.match_action_control[i*BITS_PER_CH+HALT_BIT]; // R11
    end
  endgenerate

  always_comb begin
    next_s          = s;
    next_s.prev_hit = mi.hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// *** verilog/prescaled_timer_match_core.sv ***
// Prescaled 32-bit timer with four compare channels and an APB slave
`default_nettype none
module prescaled_timer_match_core (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq
);
  import timer_pkg::*;

  core_state_t s;
  core_state_t next_s;
  logic        setup;
  logic        wr;
  logic        terminal;

  match_if mi ();

  match_unit u_match (
    .pclk    (pclk),
    .presetn (presetn),
    .mi      (mi)
  );

  assign mi.tick_count           = s.tick_count;
  assign mi.compare_value        = s.compare_value;
  assign mi.match_action_control = s.match_action_control;

  assign setup    = psel & ~penable;
  assign wr       = psel & penable & s.ready & pwrite;
  assign terminal = s.divider_count == s.divider_limit;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;

    // Counting; a halting match freezes the timer at the match value and the divider count where it stands
    if (s.run_enable && !(|mi.halt_event)) begin // R11 R13
      if (terminal) begin
        next_s.divider_count = RESET_WORD; // R7
        if (|mi.clear_hit) begin
          next_s.tick_count = RESET_WORD; // R10
        end else begin
          // All ones wraps to zero with no side effect
          next_s.tick_count = s.tick_count + 32'h1; // R1 R2 R3 R8
        end
      end else begin
        next_s.divider_count = s.divider_count + 32'h1; // R6
      end
    end

    // Bus answer, one wait-free access after every setup
    next_s.ready  = setup;
    next_s.slverr = 1'b0;
    if (setup) begin
      next_s.rdata = RESET_WORD;
      if (paddr == ADDR_PENDING) begin
        next_s.rdata[NUM_CH-1:0] = s.pending_flags;
      end else if (paddr == ADDR_RUN) begin
        next_s.rdata[EN_BIT]  = s.run_enable;
        next_s.rdata[RST_BIT] = s.run_clear;
      end else if (paddr == ADDR_TICK) begin
        next_s.rdata = s.tick_count;
      end else if (paddr == ADDR_LIMIT) begin
        next_s.rdata = s.divider_limit;
      end else if (paddr == ADDR_DIVCNT) begin
        next_s.rdata = s.divider_count;
      end else if (paddr == ADDR_MCA) begin
        next_s.rdata[MCA_WIDTH-1:0] = s.match_action_control; // R12
      end else if (paddr == ADDR_CV0) begin
        next_s.rdata = s.compare_value[0];
      end else if (paddr == ADDR_CV1) begin
        next_s.rdata = s.compare_value[1];
      end else if (paddr == ADDR_CV2) begin
        next_s.rdata = s.compare_value[2];
      end else if (paddr == ADDR_CV3) begin
        next_s.rdata = s.compare_value[3];
      end else begin
        next_s.slverr = 1'b1;
      end
    end

    // Register writes; software loads beat counting
    if (wr) begin
      if (paddr == ADDR_RUN) begin
        next_s.run_enable = pwdata[EN_BIT];
        next_s.run_clear  = pwdata[RST_BIT];
      end else if (paddr == ADDR_TICK) begin
        next_s.tick_count = pwdata;
      end else if (paddr == ADDR_LIMIT) begin
        next_s.divider_limit = pwdata; // R5
      end else if (paddr == ADDR_DIVCNT) begin
        next_s.divider_count = pwdata;
      end else if (paddr == ADDR_MCA) begin
        // Upper bits are not stored, so they cannot misbehave
        next_s.match_action_control = pwdata[MCA_WIDTH-1:0]; // R12
      end else if (paddr == ADDR_CV0) begin
        next_s.compare_value[0] = pwdata;
      end else if (paddr == ADDR_CV1) begin
        next_s.compare_value[1] = pwdata;
      end else if (paddr == ADDR_CV2) begin
        next_s.compare_value[2] = pwdata;
      end else if (paddr == ADDR_CV3) begin
        next_s.compare_value[3] = pwdata;
      end
    end

    // Flags: a set in the clearing cycle survives
    next_s.pending_flags = s.pending_flags;
    if (wr && paddr == ADDR_PENDING) begin
      next_s.pending_flags = s.pending_flags & ~pwdata[NUM_CH-1:0]; // R15
    end
    next_s.pending_flags = next_s.pending_flags | mi.irq_event; // R9 R15

    // Halt wins over a simultaneous software enable
    if (|mi.halt_event) begin
      next_s.run_enable = 1'b0; // R11
    end

    // Held clear overrides every other counter update
    if (s.run_clear) begin
      next_s.tick_count    = RESET_WORD; // R14
      next_s.divider_count = RESET_WORD; // R14
    end

    next_s.irq = |next_s.pending_flags; // R17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.rdata;
  assign pready  = s.ready;
  assign pslverr = s.slverr;
  assign irq     = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic quiet;
  assign quiet = ~wr & ~s.run_clear & ~(|mi.halt_event);

  AST_WRAP: assert property ( // R2
    quiet && s.run_enable && terminal && !(|mi.clear_hit) &&
    s.tick_count == 32'hffff_ffff |=> s.tick_count == 32'h0)
    else $error("timer did not roll over to zero");

  AST_NO_ROLL_FLAG: assert property ( // R3
    !(|mi.irq_event) && !wr |=>
    (s.pending_flags & ~$past(s.pending_flags)) == '0)
    else $error("flag set without a match interrupt");

  AST_DIV_INC: assert property ( // R6
    quiet && s.run_enable && !terminal |=>
    s.divider_count == $past(s.divider_count) + 32'h1 &&
    $stable(s.tick_count))
    else $error("divider count did not step");

  AST_TERMINAL: assert property ( // R7
    quiet && s.run_enable && terminal && !(|mi.clear_hit) |=>
    s.divider_count == 32'h0 &&
    s.tick_count == $past(s.tick_count) + 32'h1)
    else $error("terminal count did not advance timer");

  AST_LIMIT_ONE: assert property ( // R8
    quiet && s.run_enable && s.divider_limit == 32'h1 &&
    s.divider_count == 32'h0 && !(|mi.halt_event) ##1
    quiet && !(|mi.clear_hit) |=>
    s.tick_count == $past(s.tick_count, 2) + 32'h1)
    else $error("limit one did not give two clocks per step");

  AST_HOLD: assert property ( // R13
    quiet && !s.run_enable |=>
    $stable(s.tick_count) && $stable(s.divider_count))
    else $error("counters moved while disabled");

  AST_CLEAR: assert property ( // R14
    s.run_clear |=> s.tick_count == 32'h0 && s.divider_count == 32'h0)
    else $error("counters not held at zero");

  AST_IRQ_SET: assert property ( // R9
    |mi.irq_event |=> (s.pending_flags & $past(mi.irq_event)) ==
    $past(mi.irq_event))
    else $error("match interrupt did not set its flag");

  AST_MATCH_CLEAR: assert property ( // R10
    quiet && s.run_enable && terminal &&
    |mi.clear_hit |=> s.tick_count == 32'h0)
    else $error("match did not reset the timer");

  AST_HALT: assert property ( // R11
    |mi.halt_event |=> !s.run_enable)
    else $error("match did not stop the counters");

  AST_W1C: assert property ( // R15
    wr && paddr == ADDR_PENDING && !(|mi.irq_event) |=>
    s.pending_flags == ($past(s.pending_flags) & ~$past(pwdata[3:0])))
    else $error("flag write one did not clear");

  AST_IRQ_OUT: assert property ( // R17
    irq == (|s.pending_flags))
    else $error("interrupt output disagrees with flags");

  AST_MCA_RESERVED: assert property ( // R12
    pready && s.rdata[31:MCA_WIDTH] != '0 |->
    $past(paddr) != ADDR_MCA)
    else $error("reserved control bits read as nonzero");

  AST_READY_ONCE: assert property (
    setup |=> pready ##1 !pready || setup)
    else $error("bus answer not one cycle");

  AST_HALT_HOLD: assert property ( // R11
    (|mi.halt_event) && !wr && !s.run_clear |=>
    $stable(s.tick_count) && $stable(s.divider_count))
    else $error("counters moved past a halting match");

  AST_LIMIT_ZERO: assert property ( // R8
    quiet && s.run_enable && s.divider_limit == 32'h0 &&
    s.divider_count == 32'h0 && !(|mi.clear_hit) |=>
    s.tick_count == $past(s.tick_count) + 32'h1)
    else $error("limit zero did not step every clock");

  // Channel 0 stands for all: the comparator is one generate loop
  AST_MATCH_EDGE: assert property ( // R16
    quiet && s.run_enable && terminal && !(|mi.clear_hit) &&
    s.match_action_control[IRQ_BIT] &&
    s.tick_count + 32'h1 == s.compare_value[0] |=>
    ##1 s.pending_flags[0])
    else $error("channel 0 match did not raise its flag");

  AST_FLAG_HOLD: assert property ( // R15
    !wr && !(|mi.irq_event) |=> $stable(s.pending_flags))
    else $error("flags changed with no event or write");

  AST_PEND_READ: assert property ( // R15
    setup && paddr == ADDR_PENDING |=>
    prdata[NUM_CH-1:0] == $past(s.pending_flags) &&
    prdata[31:NUM_CH] == '0)
    else $error("flag read returned stale data");

  ////////////////////////////////////////////////////////////////////////
  // Register writes land at the access edge
  AST_LIMIT_WRITE: assert property ( // R5
    wr && paddr == ADDR_LIMIT |=> s.divider_limit == $past(pwdata))
    else $error("divider limit write lost");

  AST_MCA_WRITE: assert property ( // R12
    wr && paddr == ADDR_MCA |=>
    s.match_action_control == $past(pwdata[MCA_WIDTH-1:0]))
    else $error("match control write lost");

  AST_RUN_WRITE: assert property ( // R13 R14
    wr && paddr == ADDR_RUN && !(|mi.halt_event) |=>
    s.run_enable == $past(pwdata[EN_BIT]) &&
    s.run_clear == $past(pwdata[RST_BIT]))
    else $error("run control write lost");

  AST_TICK_WRITE: assert property (
    wr && paddr == ADDR_TICK && !s.run_clear |=>
    s.tick_count == $past(pwdata))
    else $error("timer write lost");

  AST_DIVCNT_WRITE: assert property (
    wr && paddr == ADDR_DIVCNT && !s.run_clear |=>
    s.divider_count == $past(pwdata))
    else $error("divider count write lost");

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_cv_chk
      AST_CV_WRITE: assert property (
        wr && paddr == ADDR_CV0 + 32'(4 * g) |=>
        s.compare_value[g] == $past(pwdata))
        else $error("compare value write lost");
    end
  endgenerate

  AST_ERR_ZERO: assert property (
    pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");

  AST_READ_TICK: assert property ( // R1
    setup && paddr == ADDR_TICK |=> prdata == $past(s.tick_count))
    else $error("timer read returned stale data");

  COV_WRAP: cover property (
    s.tick_count == 32'hffff_ffff ##1 s.tick_count == 32'h0);
  COV_IRQ: cover property (|mi.irq_event ##1 irq);
  COV_HALT: cover property (|mi.halt_event ##1 !s.run_enable);
  COV_MCLR: cover property (|mi.clear_hit && terminal && s.run_enable);
  COV_ERR: cover property (pready && pslverr);
endmodule
`default_nettype wire

// *** testbench/prescaled_timer_match_core_tb_top.sv ***
// Self-checking testbench for the prescaled timer match core
`default_nettype none
module prescaled_timer_match_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [31:0] seed;
  logic [31:0] lim;
  logic [31:0] t0;
  logic [31:0] steps;
  logic [31:0] cv;
  time         t1;
  int          miscompares;
  int          checked;

  prescaled_timer_match_core DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ticks(logic [31:0] n, logic [31:0] l);
    return n / (l + 32'h1);
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t: got %h want %h", $time, seen, want);
    end
  endtask

  // Idle cycle first, so psel is never driven twice in one step
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(logic [31:0] a, logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rd, want);
  endtask

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hc2e78775;
    miscompares = 0;
    checked = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rdchk(ADDR_PENDING + 32'(4 * i), RESET_WORD);
    end
    apb(1'b0, 32'h4001_4028, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    for (int i = 0; i < NUM_CH; i++) begin
      t0 = rnd();
      wr(ADDR_CV0 + 32'(4 * i), t0);
      rdchk(ADDR_CV0 + 32'(4 * i), t0);
    end
    t0 = rnd() & 32'hfff;
    wr(ADDR_MCA, t0);
    rdchk(ADDR_MCA, t0);
    wr(ADDR_MCA, 32'h0);
    // First pass starts near all ones so the wrap is crossed
    for (int k = 0; k < 12; k++) begin
      lim = (k == 0) ? 32'h0 : rnd() % 4;
      t0 = (k == 0) ? 32'hffff_fffe : rnd();
      wr(ADDR_LIMIT, lim);
      rdchk(ADDR_LIMIT, lim);
      wr(ADDR_TICK, t0);
      wr(ADDR_DIVCNT, 32'h0);
      wr(ADDR_RUN, 32'h1);
      t1 = $time;
      repeat (rnd() % 16) @(posedge pclk);
      wr(ADDR_RUN, 32'h0);
      steps = 32'(($time - t1) / 100);
      repeat (3) @(posedge pclk);
      rdchk(ADDR_TICK, t0 + ticks(steps, lim));
      rdchk(ADDR_DIVCNT, steps % (lim + 32'h1));
      rdchk(ADDR_PENDING, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      cv = ADDR_CV0 + 32'(4 * c);
      wr(ADDR_LIMIT, 32'h0);
      wr(ADDR_TICK, 32'h0);
      wr(ADDR_DIVCNT, 32'h0);
      wr(cv, 32'h5);
      wr(ADDR_MCA, 32'h1 << (3 * c));
      wr(ADDR_RUN, 32'h1);
      repeat (10) @(posedge pclk);
      wr(ADDR_RUN, 32'h0);
      check({31'h0, irq}, 32'h1);
      rdchk(ADDR_PENDING, 32'h1 << c);
      wr(ADDR_PENDING, 32'h0);
      rdchk(ADDR_PENDING, 32'h1 << c);
      wr(ADDR_PENDING, 32'h1 << c);
      rdchk(ADDR_PENDING, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(ADDR_TICK, 32'h0);
      wr(ADDR_MCA, 32'h2 << (3 * c));
      wr(cv, 32'h3);
      wr(ADDR_LIMIT, 32'h1);
      wr(ADDR_RUN, 32'h1);
      t1 = $time;
      repeat (c + 5) @(posedge pclk);
      wr(ADDR_RUN, 32'h0);
      steps = 32'(($time - t1) / 100);
      rdchk(ADDR_TICK, ticks(steps, 32'h1) % 4);
      wr(ADDR_TICK, 32'h0);
      wr(ADDR_DIVCNT, 32'h0);
      wr(ADDR_LIMIT, 32'h0);
      wr(cv, 32'h7);
      wr(ADDR_MCA, 32'h4 << (3 * c));
      wr(ADDR_RUN, 32'h1);
      repeat (20) @(posedge pclk);
      rdchk(ADDR_RUN, 32'h0);
      rdchk(ADDR_TICK, 32'h7);
      wr(ADDR_MCA, 32'h0);
    end
    wr(ADDR_TICK, 32'h55);
    wr(ADDR_RUN, 32'h3);
    repeat (4) @(posedge pclk);
    rdchk(ADDR_TICK, 32'h0);
    rdchk(ADDR_DIVCNT, 32'h0);
    wr(ADDR_RUN, 32'h0);
    // A compare value of zero is how software sees the rollover
    wr(ADDR_TICK, 32'hffff_fffe);
    wr(ADDR_CV0, 32'h0);
    wr(ADDR_MCA, 32'h1);
    wr(ADDR_RUN, 32'h1);
    wr(ADDR_RUN, 32'h0);
    rdchk(ADDR_PENDING, 32'h1);
    rdchk(ADDR_TICK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_PENDING, 32'h1);
    wr(ADDR_MCA, 32'h0);
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////
  // Whole run is about a thousand cycles; this margin is ample
  initial begin
    #2_000_000;
    miscompares++;
    $display("BAD %0t: watchdog", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
